// >>> shared/flash_host_defs.vh
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_MHZ 200
`define CLK_HZ 200000000

// ----------------------------------------
// Pin timing, figures in ns or s; synchroniser depth in stages
// ----------------------------------------
`define T_WP_NS 90
`define T_WPH_NS 90
`define T_ACC_NS 90
`define GATE_HIGH_PULSE_MIN_NS 150
`define T_BP_NS 50000
`define T_EC_S 10
`define SYNC_STAGES 2

// Least times round up to whole cycles
`define NS_TO_CYC_UP(t) (((t) * `CLK_MHZ + 999) / 1000)
`define T_WP_CYC `NS_TO_CYC_UP(`T_WP_NS)
`define T_WPH_CYC `NS_TO_CYC_UP(`T_WPH_NS)
`define T_ACC_CYC `NS_TO_CYC_UP(`T_ACC_NS)
`define GATE_HIGH_PULSE_MIN_CYC `NS_TO_CYC_UP(`GATE_HIGH_PULSE_MIN_NS)
`define T_BP_CYC (`T_BP_NS * `CLK_MHZ / 1000)
`define T_EC_CYC (`T_EC_S * `CLK_HZ)

// ----------------------------------------
// Command addresses and bytes
// ----------------------------------------
`define ADDR_UNLOCK1 15'h5555
`define ADDR_UNLOCK2 15'h2aaa
`define BYTE_UNLOCK1 8'haa
`define BYTE_UNLOCK2 8'h55
`define BYTE_PROG 8'ha0
`define BYTE_ERASE 8'h80
`define BYTE_ID_ENTRY 8'h90
`define BYTE_ID_EXIT 8'hf0
`define BYTE_CHIP_ERASE 8'h10
`define BYTE_MAIN_ERASE 8'h30
`define BYTE_LOCKOUT 8'h40

// ----------------------------------------
// Array layout
// ----------------------------------------
`define BOOT_FIRST 15'h0000
`define BOOT_LAST 15'h1fff
`define TOGGLE_BIT 6

// ----------------------------------------
// User operation codes
// ----------------------------------------
`define OP_READ 3'h0
`define OP_PROG 3'h1
`define OP_CHIP_ERASE 3'h2
`define OP_MAIN_ERASE 3'h3
`define OP_LOCKOUT 3'h4
`define OP_ID_READ 3'h5
`define OP_ID_EXIT3 3'h6
`define OP_ID_EXIT1 3'h7

`endif

// >>> hdl/flash_pin_cycle.v
`timescale 1ns/100ps
`include "flash_host_defs.vh"

module flash_pin_cycle (
	input wire i_sys_clk,
	input wire i_sys_rst,
	input wire i_go,
	input wire i_wr,
	input wire [14:0] i_addr,
	input wire [15:0] i_wdata,
	input wire [15:0] i_dq_in,
	output reg o_done,
	output reg [15:0] o_rdata,
	output reg o_ce_n,
	output reg o_oe_n,
	output reg o_we_n,
	output reg [14:0] o_addr,
	output reg [15:0] o_dq_out,
	output reg o_dq_oe_n
);

	localparam [1:0] E_IDLE = 2'd0;
	localparam [1:0] E_ACT = 2'd1;
	localparam [1:0] E_REC = 2'd2;
	localparam integer WP_CNT = `T_WP_CYC - 1;
	localparam integer WPH_CNT = `T_WPH_CYC - 1;
	localparam integer ACC_CNT = `T_ACC_CYC + `SYNC_STAGES - 1;
	localparam integer GATE_HIGH_CNT = `GATE_HIGH_PULSE_MIN_CYC - 1;
	localparam [7:0] WP_LOAD = WP_CNT[7:0];
	localparam [7:0] WPH_LOAD = WPH_CNT[7:0];
	localparam [7:0] ACC_LOAD = ACC_CNT[7:0];
	localparam [7:0] GATE_HIGH_LOAD = GATE_HIGH_CNT[7:0];

	reg [1:0] st_q;
	reg [7:0] cnt_q;
	reg wr_q;
	reg [15:0] dq_meta_q;
	reg [15:0] dq_sync_q;

	// ----------------------------------------
	// Data pin synchroniser
	// ----------------------------------------
	always @(posedge i_sys_clk) begin
		dq_meta_q <= i_dq_in;
		dq_sync_q <= dq_meta_q;
	end

	// ----------------------------------------
	// One bus cycle: active phase, then recovery
	// ----------------------------------------
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			st_q <= E_IDLE;
			cnt_q <= 8'h00;
			wr_q <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 16'h0000;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_addr <= 15'h0000;
			o_dq_out <= 16'h0000;
			o_dq_oe_n <= 1'b1;
		end else begin
			o_done <= 1'b0;
			case (st_q)
			E_IDLE: begin
				if (i_go) begin
					o_addr <= i_addr;
					o_dq_out <= i_wdata;
					wr_q <= i_wr;
					o_ce_n <= 1'b0;
					o_oe_n <= i_wr;
					o_we_n <= ~i_wr;
					o_dq_oe_n <= ~i_wr;
					cnt_q <= i_wr ? WP_LOAD : ACC_LOAD;
					st_q <= E_ACT;
				end
			end
			E_ACT: begin
				if (cnt_q == 8'h00) begin
					if (!wr_q) begin
						o_rdata <= dq_sync_q;
					end
					// Gate and select both rise, so each toggles per read
					o_ce_n <= 1'b1;
					o_oe_n <= 1'b1;
					o_we_n <= 1'b1;
					o_dq_oe_n <= 1'b1;
					cnt_q <= wr_q ? WPH_LOAD : GATE_HIGH_LOAD;
					st_q <= E_REC;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end
			E_REC: begin
				if (cnt_q == 8'h00) begin
					o_done <= 1'b1;
					st_q <= E_IDLE;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end
			default: begin
				st_q <= E_IDLE;
			end
			endcase
		end
	end

endmodule

// >>> hdl/flash_host_ctrl.v
`timescale 1ns/100ps
`include "flash_host_defs.vh"

module flash_host_ctrl #(
	parameter [31:0] PROG_TMO_CYC = `T_BP_CYC,
	parameter [31:0] ERASE_TMO_CYC = `T_EC_CYC
) (
	input wire i_sys_clk,
	input wire i_sys_rst,
	input wire i_cmd_valid,
	input wire [2:0] i_cmd_op,
	input wire [14:0] i_cmd_addr,
	input wire [15:0] i_cmd_data,
	output reg o_cmd_ready,
	output reg o_rsp_valid,
	output reg [15:0] o_rsp_data,
	output reg o_rsp_err,
	output reg o_rsp_boot,
	output reg o_id_mode,
	output wire o_flash_ce_n,
	output wire o_flash_oe_n,
	output wire o_flash_we_n,
	output wire [14:0] o_flash_addr,
	output wire [15:0] o_flash_dq_out,
	output wire o_flash_dq_oe_n,
	input wire [15:0] i_flash_dq_in
);

	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_SEQ = 3'd1;
	localparam [2:0] S_POLL = 3'd2;
	localparam [2:0] S_READ = 3'd3;
	localparam [2:0] S_DONE = 3'd4;

	reg [2:0] st_q;
	reg [2:0] op_q;
	reg [14:0] addr_q;
	reg [15:0] data_q;
	reg [2:0] step_q;
	reg go_q;
	reg next_q;
	reg cyc_wr_q;
	reg [14:0] cyc_addr_q;
	reg [15:0] cyc_data_q;
	reg have_prev_q;
	reg prev_tog_q;
	reg err_q;
	reg [31:0] tmo_q;
	reg [31:0] limit_q;
	reg [14:0] seq_addr;
	reg [7:0] seq_byte;
	reg seq_last;
	reg seq_user_word;
	wire cyc_done;
	wire [15:0] cyc_rdata;
	wire op_polls;
	wire op_reads;
	wire [14:0] rd_addr;

	assign op_polls = (op_q == `OP_PROG) || (op_q == `OP_CHIP_ERASE) ||
		(op_q == `OP_MAIN_ERASE) || (op_q == `OP_LOCKOUT);
	assign op_reads = (op_q == `OP_READ) || (op_q == `OP_ID_READ);
	// Identification words sit at address 0 and 1
	assign rd_addr = (op_q == `OP_ID_READ) ? {14'h0000, addr_q[0]} : addr_q;

	// ----------------------------------------
	// Command sequence table
	// ----------------------------------------
	always @* begin
		seq_addr = `ADDR_UNLOCK1;
		seq_byte = `BYTE_UNLOCK1;
		seq_last = 1'b0;
		seq_user_word = 1'b0;
		case (step_q)
		3'd0: begin
			if (op_q == `OP_ID_EXIT1) begin
				seq_addr = addr_q;
				seq_byte = `BYTE_ID_EXIT;
				seq_last = 1'b1;
			end
		end
		3'd1: begin
			seq_addr = `ADDR_UNLOCK2;
			seq_byte = `BYTE_UNLOCK2;
		end
		3'd2: begin
			if (op_q == `OP_PROG) begin
				seq_byte = `BYTE_PROG;
			end else if (op_q == `OP_ID_READ) begin
				seq_byte = `BYTE_ID_ENTRY;
				seq_last = 1'b1;
			end else if (op_q == `OP_ID_EXIT3) begin
				seq_byte = `BYTE_ID_EXIT;
				seq_last = 1'b1;
			end else begin
				seq_byte = `BYTE_ERASE;
			end
		end
		3'd3: begin
			if (op_q == `OP_PROG) begin
				seq_addr = addr_q;
				seq_user_word = 1'b1;
				seq_last = 1'b1;
			end
		end
		3'd4: begin
			seq_addr = `ADDR_UNLOCK2;
			seq_byte = `BYTE_UNLOCK2;
		end
		default: begin
			seq_last = 1'b1;
			if (op_q == `OP_CHIP_ERASE) begin
				seq_byte = `BYTE_CHIP_ERASE;
			end else if (op_q == `OP_MAIN_ERASE) begin
				seq_byte = `BYTE_MAIN_ERASE;
			end else begin
				seq_byte = `BYTE_LOCKOUT;
			end
		end
		endcase
	end

	// ----------------------------------------
	// Operation sequencer
	// ----------------------------------------
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			st_q <= S_IDLE;
			op_q <= `OP_READ;
			addr_q <= 15'h0000;
			data_q <= 16'h0000;
			step_q <= 3'd0;
			go_q <= 1'b0;
			next_q <= 1'b0;
			cyc_wr_q <= 1'b0;
			cyc_addr_q <= 15'h0000;
			cyc_data_q <= 16'h0000;
			have_prev_q <= 1'b0;
			prev_tog_q <= 1'b0;
			err_q <= 1'b0;
			tmo_q <= 32'h00000000;
			limit_q <= 32'h00000000;
			o_cmd_ready <= 1'b0;
			o_rsp_valid <= 1'b0;
			o_rsp_data <= 16'h0000;
			o_rsp_err <= 1'b0;
			o_rsp_boot <= 1'b0;
			o_id_mode <= 1'b0;
		end else begin
			go_q <= 1'b0;
			o_rsp_valid <= 1'b0;
			case (st_q)
			S_IDLE: begin
				o_cmd_ready <= 1'b1;
				if (i_cmd_valid && o_cmd_ready) begin
					o_cmd_ready <= 1'b0;
					op_q <= i_cmd_op;
					addr_q <= i_cmd_addr;
					data_q <= i_cmd_data;
					step_q <= 3'd0;
					have_prev_q <= 1'b0;
					err_q <= 1'b0;
					tmo_q <= 32'h00000000;
					limit_q <= (i_cmd_op == `OP_PROG) ?
						PROG_TMO_CYC : ERASE_TMO_CYC;
					if (i_cmd_op == `OP_READ) begin
						cyc_wr_q <= 1'b0;
						cyc_addr_q <= i_cmd_addr;
						go_q <= 1'b1;
						st_q <= S_READ;
					end else begin
						st_q <= S_SEQ;
						go_q <= 1'b1;
						cyc_wr_q <= 1'b1;
						if (i_cmd_op == `OP_ID_EXIT1) begin
							cyc_addr_q <= i_cmd_addr;
							cyc_data_q <= {8'h00, `BYTE_ID_EXIT};
						end else begin
							cyc_addr_q <= `ADDR_UNLOCK1;
							cyc_data_q <= {8'h00, `BYTE_UNLOCK1};
						end
					end
				end
			end
			S_SEQ: begin
				if (cyc_done) begin
					if (seq_last) begin
						if (op_polls) begin
							cyc_wr_q <= 1'b0;
							cyc_addr_q <= addr_q;
							go_q <= 1'b1;
							st_q <= S_POLL;
						end else if (op_reads) begin
							o_id_mode <= 1'b1;
							cyc_wr_q <= 1'b0;
							cyc_addr_q <= rd_addr;
							go_q <= 1'b1;
							st_q <= S_READ;
						end else begin
							o_id_mode <= 1'b0;
							st_q <= S_DONE;
						end
					end else begin
						// Step advances now; next step's words and strobe load together one cycle later
						step_q <= step_q + 3'd1;
						next_q <= 1'b1;
					end
				end else begin
					cyc_addr_q <= seq_addr;
					cyc_data_q <= seq_user_word ? data_q :
						{8'h00, seq_byte};
					if (next_q) begin
						next_q <= 1'b0;
						go_q <= 1'b1;
					end
				end
			end
			S_POLL: begin
				if (tmo_q != 32'hffffffff) begin
					tmo_q <= tmo_q + 32'h00000001;
				end
				if (cyc_done) begin
					have_prev_q <= 1'b1;
					prev_tog_q <= cyc_rdata[`TOGGLE_BIT];
					if (have_prev_q &&
						(prev_tog_q == cyc_rdata[`TOGGLE_BIT])) begin
						st_q <= S_DONE;
					end else if (tmo_q >= limit_q) begin
						err_q <= 1'b1;
						st_q <= S_DONE;
					end else begin
						go_q <= 1'b1;
					end
				end
			end
			S_READ: begin
				if (cyc_done) begin
					st_q <= S_DONE;
				end
			end
			default: begin
				o_rsp_valid <= 1'b1;
				o_rsp_data <= cyc_rdata;
				o_rsp_err <= err_q;
				o_rsp_boot <= (addr_q <= `BOOT_LAST);
				st_q <= S_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------
	// Pin cycle engine
	// ----------------------------------------
	flash_pin_cycle u_cycle (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_go(go_q),
		.i_wr(cyc_wr_q),
		.i_addr(cyc_addr_q),
		.i_wdata(cyc_data_q),
		.i_dq_in(i_flash_dq_in),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.o_ce_n(o_flash_ce_n),
		.o_oe_n(o_flash_oe_n),
		.o_we_n(o_flash_we_n),
		.o_addr(o_flash_addr),
		.o_dq_out(o_flash_dq_out),
		.o_dq_oe_n(o_flash_dq_oe_n)
	);

endmodule

// >>> bench/flash_host_chk.sv
`timescale 1ns/100ps
module flash_host_chk (
	input wire i_sys_clk,
	input wire i_sys_rst,
	input wire i_cmd_valid,
	input wire [2:0] i_cmd_op,
	input wire [14:0] i_cmd_addr,
	input wire o_cmd_ready,
	input wire o_rsp_valid,
	input wire o_rsp_boot,
	input wire o_id_mode,
	input wire o_flash_ce_n,
	input wire o_flash_oe_n,
	input wire o_flash_we_n,
	input wire [14:0] o_flash_addr,
	input wire [15:0] o_flash_dq_out,
	input wire o_flash_dq_oe_n
);
	reg [2:0] op_q;
	reg [14:0] ad_q;
	reg [2:0] wc_q;
	reg [5:0] hi_q;
	// Gate high-time counter saturates so an idle bus never wraps
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			op_q <= 3'h0;
			ad_q <= 15'h0;
			wc_q <= 3'h0;
			hi_q <= 6'h3f;
		end else begin
			hi_q <= o_flash_oe_n ? hi_q + {5'h0, ~&hi_q} : 6'h0;
			if (i_cmd_valid && o_cmd_ready) begin
				op_q <= i_cmd_op;
				ad_q <= i_cmd_addr;
				wc_q <= 3'h0;
			end else if ($fell(o_flash_we_n))
				wc_q <= wc_q + 3'h1;
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	sequence low18;
		!o_flash_we_n[*8] ##1 !o_flash_we_n[*8] ##1 !o_flash_we_n[*2];
	endsequence
	chk_gate_write: assert property (
		!o_flash_we_n && !o_flash_ce_n |-> o_flash_oe_n && !o_flash_dq_oe_n
	) else $error("gate low in write");
	chk_write_pulse: assert property (
		$fell(o_flash_we_n) |-> low18 ##1 o_flash_we_n
	) else $error("write pulse width");
	chk_gate_high: assert property (
		$fell(o_flash_oe_n) |-> hi_q >= 6'd30 && !o_flash_ce_n
	) else $error("gate high too short");
	chk_poll_addr: assert property (
		$fell(o_flash_oe_n) && op_q != 3'h0 && op_q < 3'h5
		|-> o_flash_addr == ad_q
	) else $error("poll address moved");
	chk_id_read: assert property (
		$fell(o_flash_oe_n) && op_q == 3'h5
		|-> o_flash_addr == {14'h0, ad_q[0]}
	) else $error("id read address");
	chk_erase_byte: assert property (
		$fell(o_flash_we_n) && wc_q == 3'h5 && op_q[2:1] == 2'b01
		|-> o_flash_dq_out == (op_q[0] ? 16'h0030 : 16'h0010)
	) else $error("erase final byte");
	chk_cmd_byte: assert property (
		$fell(o_flash_we_n) && !(op_q == 3'h1 && wc_q == 3'h3)
		|-> o_flash_dq_out[15:8] == 8'h00
	) else $error("command high byte");
	chk_boot_flag: assert property (
		o_rsp_valid |-> o_rsp_boot == (ad_q <= 15'h1fff)
	) else $error("boot flag");
	chk_id_exit: assert property (
		o_rsp_valid && op_q[2:1] == 2'b11 |-> ##[0:1] !o_id_mode
	) else $error("id mode kept");
endmodule

bind flash_host_ctrl flash_host_chk u_flash_host_chk (
	.i_sys_clk(i_sys_clk),
	.i_sys_rst(i_sys_rst),
	.i_cmd_valid(i_cmd_valid),
	.i_cmd_op(i_cmd_op),
	.i_cmd_addr(i_cmd_addr),
	.o_cmd_ready(o_cmd_ready),
	.o_rsp_valid(o_rsp_valid),
	.o_rsp_boot(o_rsp_boot),
	.o_id_mode(o_id_mode),
	.o_flash_ce_n(o_flash_ce_n),
	.o_flash_oe_n(o_flash_oe_n),
	.o_flash_we_n(o_flash_we_n),
	.o_flash_addr(o_flash_addr),
	.o_flash_dq_out(o_flash_dq_out),
	.o_flash_dq_oe_n(o_flash_dq_oe_n)
);

// >>> bench/flash_dev_model.sv
`timescale 1ns/100ps
module flash_dev_model #(
	parameter [15:0] MAKER = 16'h00c3, // Arbitrary value
	parameter [15:0] PART = 16'h005a, // Arbitrary value
	parameter int BUSY_RD = 3
) (
	input wire i_ce_n,
	input wire i_oe_n,
	input wire i_we_n,
	input wire [14:0] i_addr,
	input wire [15:0] i_dq,
	output wire [15:0] o_dq
);
	logic [15:0] mem [0:32767];
	logic [47:0] hb = 48'h0;
	logic [15:0] v = 16'h0;
	bit id = 0;
	bit lk = 0;
	bit tg = 0;
	bit bz = 0;
	int busy = 0;
	wire wr = !i_ce_n && !i_we_n;
	wire rd = !i_ce_n && !i_oe_n && i_we_n;
	// Released bus shows the inverse of the last word
	assign o_dq = rd ? v : ~v;
	initial foreach (mem[k]) mem[k] = 16'hffff;
	always @(posedge wr) begin
		#1;
		hb = {hb[39:0], i_dq[7:0]};
		if (hb[31:8] == 24'haa55a0) begin
			if (!lk || i_addr > 15'h1fff)
				mem[i_addr] = i_dq;
			busy = BUSY_RD;
		end else if (hb[47:8] == 40'haa5580aa55) begin
			lk = lk || hb[7:0] == 8'h40;
			for (int k = 0; k < 32768; k++)
				if (k > 'h1fff ? hb[7:0] != 8'h40 : hb[7:0] == 8'h10 && !lk)
					mem[k] = 16'hffff;
			busy = BUSY_RD;
		end else if (hb[23:0] == 24'haa5590)
			id = 1;
		else if (hb[7:0] == 8'hf0)
			id = 0;
	end
	always @(posedge rd) begin
		#1;
		bz = busy > 0;
		if (bz)
			busy--;
		tg = tg ^ bz;
		v = id ? (i_addr[0] ? PART : MAKER) : mem[i_addr];
		if (bz)
			v[6] = tg;
	end
endmodule

// >>> bench/flash_host_ctrl_tb.sv
`timescale 1ns/100ps
module flash_host_ctrl_tb;
	localparam [15:0] MK = 16'h00c3; // Arbitrary value
	localparam [15:0] PT = 16'h005a; // Arbitrary value
	logic i_sys_clk = 0;
	logic i_sys_rst = 1;
	logic i_cmd_valid = 0;
	logic [2:0] i_cmd_op = 3'h0;
	logic [14:0] i_cmd_addr = 15'h0;
	logic [15:0] i_cmd_data = 16'h0;
	wire o_cmd_ready, o_rsp_valid, o_rsp_err, o_rsp_boot, o_id_mode;
	wire o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_flash_dq_oe_n;
	wire [14:0] o_flash_addr;
	wire [15:0] o_rsp_data, o_flash_dq_out, dev_q, i_flash_dq_in;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [15:0] m [int];
	bit id = 0;
	bit lk = 0;
	logic [14:0] aq [$] = '{15'h1fff, 15'h2000};
	assign i_flash_dq_in = o_flash_dq_oe_n ? dev_q : o_flash_dq_out;
	always #2.5 i_sys_clk = ~i_sys_clk;
	flash_host_ctrl #(.ERASE_TMO_CYC(32'd2000)) u_flash_host_ctrl (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_cmd_valid(i_cmd_valid),
		.i_cmd_op(i_cmd_op),
		.i_cmd_addr(i_cmd_addr),
		.i_cmd_data(i_cmd_data),
		.o_cmd_ready(o_cmd_ready),
		.o_rsp_valid(o_rsp_valid),
		.o_rsp_data(o_rsp_data),
		.o_rsp_err(o_rsp_err),
		.o_rsp_boot(o_rsp_boot),
		.o_id_mode(o_id_mode),
		.o_flash_ce_n(o_flash_ce_n),
		.o_flash_oe_n(o_flash_oe_n),
		.o_flash_we_n(o_flash_we_n),
		.o_flash_addr(o_flash_addr),
		.o_flash_dq_out(o_flash_dq_out),
		.o_flash_dq_oe_n(o_flash_dq_oe_n),
		.i_flash_dq_in(i_flash_dq_in)
	);
	flash_dev_model #(.MAKER(MK), .PART(PT)) u_flash_dev_model (
		.i_ce_n(o_flash_ce_n),
		.i_oe_n(o_flash_oe_n),
		.i_we_n(o_flash_we_n),
		.i_addr(o_flash_addr),
		.i_dq(i_flash_dq_in),
		.o_dq(dev_q)
	);
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task close_out;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	function logic [15:0] rdv(input logic [14:0] a);
		if (id)
			return a[0] ? PT : MK;
		return m.exists(a) ? m[a] : 16'hffff;
	endfunction
	task op(input logic [2:0] o, input logic [14:0] a, input logic [15:0] d);
		@(negedge i_sys_clk);
		i_cmd_op = o;
		i_cmd_addr = a;
		i_cmd_data = d;
		i_cmd_valid = 1;
		while (o_cmd_ready !== 1'b1)
			@(negedge i_sys_clk);
		@(negedge i_sys_clk);
		i_cmd_valid = 0;
		while (o_rsp_valid !== 1'b1)
			@(negedge i_sys_clk);
		case (o)
		3'h1: if (!lk || a > 15'h1fff) m[a] = d;
		3'h2: foreach (m[k]) if (k > 'h1fff || !lk) m[k] = 16'hffff;
		3'h3: foreach (m[k]) if (k > 'h1fff) m[k] = 16'hffff;
		3'h4: lk = 1;
		3'h5: id = 1;
		3'h6, 3'h7: id = 0;
		default: ;
		endcase
		if (o == 3'h0 || o == 3'h5)
			chk("data", o_rsp_data, rdv(a));
		chk("err", {15'h0, o_rsp_err}, 16'h0);
		chk("boot", {15'h0, o_rsp_boot}, {15'h0, a <= 15'h1fff});
		chk("id", {15'h0, o_id_mode}, {15'h0, id});
	endtask
	task rd_all(input string n);
		foreach (aq[i]) op(3'h0, aq[i], 16'h0);
		$display("test %s done", n);
	endtask
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			close_out;
		end
	end
	initial begin
		logic [14:0] a;
		a = 15'($urandom(33));
		repeat (4) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		i_sys_rst = 0;
		op(3'h5, 15'h0, 16'h0);
		op(3'h5, 15'h1, 16'h0);
		op(3'h0, 15'h1, 16'h0);
		op(3'h6, a, 16'h0);
		op(3'h0, 15'h1, 16'h0);
		op(3'h5, 15'h0, 16'h0);
		op(3'h7, a, 16'h0);
		op(3'h0, 15'h0, 16'h0);
		$display("test id done");
		repeat (4) aq.push_back(15'($urandom));
		foreach (aq[i]) op(3'h1, aq[i], 16'($urandom));
		rd_all("program");
		op(3'h3, aq[2], 16'h0);
		rd_all("main erase");
		foreach (aq[i]) op(3'h1, aq[i], 16'($urandom));
		op(3'h4, aq[3], 16'h0);
		op(3'h1, aq[0], 16'h1234);
		op(3'h2, aq[1], 16'h0);
		rd_all("lockout");
		close_out;
	end
endmodule
